// file: motor_stall_phase_order_protect.sv
// Phase order and stall protection stages with counters and fault log.
// Assumes fundamental current magnitudes on the ref_clk domain.
//
// Our own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
module motor_stall_phase_order_protect import prot_pkg::*; #(
  parameter int MS_CYCLES_P = MS_CYCLES,
  parameter int FORCE_MS_P = FORCE_TIMEOUT_MS
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire meas_t meas,
  input wire logic panel_button,
  output stage_out_t stage_out,
  output logic force_active,
  output logic motor_stopped
);
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic force_on;
    logic inv;
    logic [1:0] grp;
    logic [3:0] fstat;
    logic [15:0] lvl;
    logic [15:0] nomst;
    logic [15:0] dt;
    logic [15:0] inverse_time_multiplier;
    logic [15:0] imot_a;
    logic [31:0] date;
    logic [26:0] tod;
    logic [2:0] log_sel;
    logic [19:0] ms_div;
    logic ms_tick;
    logic [2:0] btn_sync;
    logic btn_stable;
    logic [19:0] force_ms;
    logic stopped;
    logic startup;
    logic po_start;
    logic po_trip;
    logic [7:0] po_ms;
    logic [15:0] po_flt;
    logic [7:0] po_elapsed_delay_pct;
    logic [15:0] po_scnt;
    logic [15:0] po_tcnt;
    logic [8:0] since_low;
    logic st_active;
    logic st_trip;
    logic [23:0] st_ms;
    logic [15:0] st_flt;
    logic [7:0] st_elapsed_delay_pct;
    logic [15:0] st_scnt;
    logic [15:0] st_tcnt;
    logic po_pend;
    logic st_pend;
    log_entry_t po_ent;
    log_entry_t st_ent;
    stage_out_t out;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic wr_go;
  logic rd_go;
  logic ctrl_wr;
  logic po_cond;
  logic [31:0] ratio_full;
  logic [15:0] ratio_pct;
  logic [63:0] inv_full;
  logic [31:0] op_ms;
  logic [31:0] st_pct;
  logic [31:0] lvl_amps;
  logic [31:0] nomst_amps;
  logic start_evt;
  logic btn_press;
  logic [3:0] log_cnt;
  log_entry_t log_rd;
  logic log_valid;

  assign waitrequest = (read | write) & ~st_ff.ack;
  assign wr_go = write & st_ff.ack;
  assign rd_go = read & ~st_ff.ack;
  assign ctrl_wr = wr_go & (address == CTRL_OFS);

  // Sequence ratio in percent, saturating
  assign ratio_full = (meas.pos == 16'h0000) ? 32'h0000_0000 :
    ({16'h0000, meas.neg} * PCT_FULL) / {16'h0000, meas.pos};
  assign ratio_pct = (ratio_full[31:16] != 16'h0000) ? 16'hffff :
    ratio_full[15:0];
  assign po_cond = st_ff.startup & (meas.avg > PO_AVG_MIN) &
    (({16'h0000, meas.neg} * PCT_FULL) >
     ({16'h0000, meas.pos} * PO_RATIO_PCT));

  // Operate time in ms, from the fundamental phase current in inverse mode, else from dt
  assign inv_full = (meas.iph == 16'h0000) ? 64'h0000_0000_00ff_ffff :
    ({48'h0, st_ff.inverse_time_multiplier} * 64'(TENTH_MS) * {48'h0, st_ff.nomst} *
     {48'h0, st_ff.nomst}) / ({48'h0, meas.iph} * {48'h0, meas.iph});
  assign op_ms = st_ff.inv ?
    ((inv_full[63:24] != 40'h0) ? 32'h00ff_ffff : inv_full[31:0]) :
    ({16'h0000, st_ff.dt} * 32'(TENTH_MS));
  assign st_pct = (op_ms == 32'h0) ? PCT_FULL :
    ({8'h00, st_ff.st_ms} * PCT_FULL) / op_ms;
  assign lvl_amps = ({16'h0000, st_ff.lvl} * {16'h0000, st_ff.imot_a}) /
    PCT_FULL;
  assign nomst_amps = ({16'h0000, st_ff.nomst} * {16'h0000, st_ff.imot_a}) /
    PCT_FULL;
  assign start_evt = ~st_ff.st_active & (meas.iph > st_ff.lvl) &
    (st_ff.since_low <= 9'(START_WIN_MS));
  assign btn_press = (st_ff.btn_sync[1] == st_ff.btn_sync[2]) &
    st_ff.btn_sync[2] & ~st_ff.btn_stable;
  assign log_valid = {1'b0, st_ff.log_sel} < log_cnt;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = (read | write) & ~st_ff.ack;
    nxt_st.po_pend = 1'b0;
    nxt_st.st_pend = st_ff.st_pend & st_ff.po_pend;
    // Millisecond time base and time of day
    nxt_st.ms_tick = 1'b0;
    if (st_ff.ms_div == 20'(MS_CYCLES_P - 1)) begin
      nxt_st.ms_div = 20'h00000;
      nxt_st.ms_tick = 1'b1;
    end else begin
      nxt_st.ms_div = st_ff.ms_div + 20'h00001;
    end
    if (st_ff.ms_tick) begin
      nxt_st.tod = (st_ff.tod == MS_PER_DAY - 27'h1) ? 27'h0 :
        st_ff.tod + 27'h1;
    end
    // Panel button sync and force timeout
    nxt_st.btn_sync = {st_ff.btn_sync[1:0], panel_button};
    if (st_ff.btn_sync[1] == st_ff.btn_sync[2]) begin
      nxt_st.btn_stable = st_ff.btn_sync[2];
    end
    if (btn_press || !st_ff.force_on) begin
      nxt_st.force_ms = 20'h00000;
    end else if (st_ff.ms_tick && st_ff.force_ms != 20'(FORCE_MS_P)) begin
      nxt_st.force_ms = st_ff.force_ms + 20'h00001;
    end
    if (st_ff.force_ms == 20'(FORCE_MS_P)) begin
      nxt_st.force_on = 1'b0;
    end
    // Motor status
    nxt_st.stopped = meas.avg < CUR_STOP;
    // Phase order stage
    if (po_cond) begin
      nxt_st.po_start = 1'b1;
      if (!st_ff.po_start) begin
        nxt_st.po_ms = 8'h00;
        nxt_st.po_flt = ratio_pct;
      end else begin
        if (ratio_pct > st_ff.po_flt) begin
          nxt_st.po_flt = ratio_pct;
        end
        if (st_ff.ms_tick && !st_ff.po_trip) begin
          nxt_st.po_ms = st_ff.po_ms + 8'h01;
          if (st_ff.po_ms == 8'(PO_TRIP_MS - 1)) begin
            nxt_st.po_trip = 1'b1;
            nxt_st.po_pend = 1'b1;
          end
        end
      end
    end else begin
      nxt_st.po_start = 1'b0;
      nxt_st.po_trip = 1'b0;
      nxt_st.po_pend = st_ff.po_start & ~st_ff.po_trip;
    end
    nxt_st.po_elapsed_delay_pct = 8'(({24'h0, nxt_st.po_ms} * PCT_FULL) /
      32'(PO_TRIP_MS));
    // Stall stage
    if (meas.iph < CUR_STOP) begin
      nxt_st.since_low = 9'h000;
    end else if (st_ff.ms_tick && st_ff.since_low != 9'h1ff) begin
      nxt_st.since_low = st_ff.since_low + 9'h001;
    end
    if (!st_ff.st_active) begin
      if (start_evt) begin
        nxt_st.st_active = 1'b1;
        nxt_st.st_ms = 24'h000000;
        nxt_st.st_flt = meas.iph;
      end
    end else if (meas.iph < CUR_RELEASE) begin
      nxt_st.st_active = 1'b0;
      nxt_st.st_trip = 1'b0;
      nxt_st.startup = 1'b0;
    end else begin
      if (meas.iph > st_ff.st_flt) begin
        nxt_st.st_flt = meas.iph;
      end
      if (!st_ff.st_trip) begin
        if ({8'h00, st_ff.st_ms} >= op_ms) begin
          nxt_st.st_trip = 1'b1;
          nxt_st.st_pend = 1'b1;
        end else if (st_ff.ms_tick) begin
          nxt_st.st_ms = st_ff.st_ms + 24'h000001;
        end
      end
    end
    nxt_st.st_elapsed_delay_pct = (st_pct > PCT_FULL) ? 8'(PCT_FULL) : st_pct[7:0];
    if (st_ff.stopped) begin
      nxt_st.startup = 1'b1;
    end
    // Counters, event set wins over a software clear
    nxt_st.po_scnt = ((wr_go && address == PO_CNT_OFS) ? 16'h0 :
      st_ff.po_scnt) + 16'({15'h0, po_cond & ~st_ff.po_start});
    nxt_st.po_tcnt = ((wr_go && address == PO_CNT_OFS) ? 16'h0 :
      st_ff.po_tcnt) + 16'({15'h0, nxt_st.po_trip & ~st_ff.po_trip});
    nxt_st.st_scnt = ((wr_go && address == ST_CNT_OFS) ? 16'h0 :
      st_ff.st_scnt) + 16'({15'h0, nxt_st.st_active & ~st_ff.st_active});
    nxt_st.st_tcnt = ((wr_go && address == ST_CNT_OFS) ? 16'h0 :
      st_ff.st_tcnt) + 16'({15'h0, nxt_st.st_trip & ~st_ff.st_trip});
    // Fault record capture
    if (nxt_st.po_pend) begin
      nxt_st.po_ent = '{date: st_ff.date, tod: st_ff.tod, stage: 1'b0,
        grp: st_ff.grp, elapsed_delay_pct: nxt_st.po_elapsed_delay_pct, flt: nxt_st.po_flt};
    end
    if (nxt_st.st_pend && !st_ff.st_pend) begin
      nxt_st.st_ent = '{date: st_ff.date, tod: st_ff.tod, stage: 1'b1,
        grp: st_ff.grp, elapsed_delay_pct: 8'(PCT_FULL), flt: nxt_st.st_flt};
    end
    // Register writes
    if (wr_go) begin
      unique case (address)
        CTRL_OFS: begin
          nxt_st.force_on = writedata[CTRL_FORCE_BIT];
          nxt_st.inv = writedata[CTRL_INV_BIT];
          nxt_st.grp = writedata[CTRL_GRP_LSB +: 2];
          nxt_st.fstat = writedata[CTRL_FST_LSB +: 4];
        end
        START_LVL_OFS: nxt_st.lvl = writedata[15:0];
        NOM_START_OFS: nxt_st.nomst = writedata[15:0];
        DT_TIME_OFS: nxt_st.dt = writedata[15:0];
        INV_MULT_OFS: nxt_st.inverse_time_multiplier = writedata[15:0];
        IMOT_AMPS_OFS: nxt_st.imot_a = writedata[15:0];
        DATE_OFS: nxt_st.date = writedata;
        TOD_OFS: nxt_st.tod = writedata[26:0];
        LOG_SEL_OFS: nxt_st.log_sel = writedata[2:0];
        default: ;
      endcase
    end
    // Register reads
    if (rd_go) begin
      unique case (address)
        CTRL_OFS: nxt_st.rdata = {24'h0, st_ff.fstat, st_ff.grp,
          st_ff.inv, st_ff.force_on};
        START_LVL_OFS: nxt_st.rdata = {16'h0, st_ff.lvl};
        NOM_START_OFS: nxt_st.rdata = {16'h0, st_ff.nomst};
        DT_TIME_OFS: nxt_st.rdata = {16'h0, st_ff.dt};
        INV_MULT_OFS: nxt_st.rdata = {16'h0, st_ff.inverse_time_multiplier};
        IMOT_AMPS_OFS: nxt_st.rdata = {16'h0, st_ff.imot_a};
        STATUS_OFS: nxt_st.rdata = {26'h0, st_ff.stopped, st_ff.force_on,
          st_ff.out};
        RATIO_OFS: nxt_st.rdata = {16'h0, ratio_pct};
        PHASE_CUR_OFS: nxt_st.rdata = {16'h0, meas.iph};
        LVL_AMPS_OFS: nxt_st.rdata = lvl_amps;
        NOMST_AMPS_OFS: nxt_st.rdata = nomst_amps;
        PO_CNT_OFS: nxt_st.rdata = {st_ff.po_tcnt, st_ff.po_scnt};
        ST_CNT_OFS: nxt_st.rdata = {st_ff.st_tcnt, st_ff.st_scnt};
        PO_REC_OFS: nxt_st.rdata = {st_ff.po_flt, 8'h0, st_ff.po_elapsed_delay_pct};
        ST_REC_OFS: nxt_st.rdata = {st_ff.st_flt, 8'h0, st_ff.st_elapsed_delay_pct};
        DATE_OFS: nxt_st.rdata = st_ff.date;
        TOD_OFS: nxt_st.rdata = {5'h0, st_ff.tod};
        LOG_SEL_OFS: nxt_st.rdata = {29'h0, st_ff.log_sel};
        LOG_DATE_OFS: nxt_st.rdata = log_rd.date;
        LOG_TOD_OFS: nxt_st.rdata = {5'h0, log_rd.tod};
        LOG_INFO_OFS: nxt_st.rdata = {4'h0, log_valid, log_rd.stage,
          log_rd.grp, log_rd.elapsed_delay_pct, log_rd.flt};
        default: nxt_st.rdata = 32'h0;
      endcase
    end
    // Stage outputs, forced bits only while the test flag is on
    nxt_st.out = stage_out_t'{po_start: st_ff.po_start,
      po_trip: st_ff.po_trip, st_start: st_ff.st_active,
      st_trip: st_ff.st_trip} | (st_ff.fstat & {4{st_ff.force_on}});
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
      st_ff.lvl <= START_LVL_RST;
      st_ff.nomst <= NOM_START_RST;
      st_ff.dt <= DT_TIME_RST;
      st_ff.inverse_time_multiplier <= INV_MULT_RST;
      st_ff.imot_a <= IMOT_AMPS_RST;
      st_ff.since_low <= 9'h1ff;
    end else begin
      st_ff <= nxt_st;
    end
  end

  fault_log_mem #(
    .DEPTH(LOG_DEPTH),
    .WIDTH($bits(log_entry_t))
  ) u_log (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .we(st_ff.po_pend | st_ff.st_pend),
    .wdata(st_ff.po_pend ? st_ff.po_ent : st_ff.st_ent),
    .rsel(st_ff.log_sel),
    .rdata(log_rd),
    .count(log_cnt)
  );

  assign readdata = st_ff.rdata;
  assign stage_out = st_ff.out;
  assign force_active = st_ff.force_on;
  assign motor_stopped = st_ff.stopped;

  property p_po_enter;
    @(posedge ref_clk) disable iff (!nrst)
    $rose(st_ff.po_start) |-> $past(st_ff.startup) &&
      ($past(meas.avg) > PO_AVG_MIN);
  endproperty
  a_po_enter: assert property (p_po_enter)
    else $error("phase order started outside its condition");

  property p_po_trip;
    @(posedge ref_clk) disable iff (!nrst)
    $rose(st_ff.po_trip) |-> st_ff.po_ms == 8'(PO_TRIP_MS) && st_ff.po_start;
  endproperty
  a_po_trip: assert property (p_po_trip)
    else $error("phase order trip not at its delay");

  property p_st_start;
    @(posedge ref_clk) disable iff (!nrst)
    $rose(st_ff.st_active) |-> $past(st_ff.since_low) <= 9'(START_WIN_MS) &&
      $past(meas.iph) > $past(st_ff.lvl);
  endproperty
  a_st_start: assert property (p_st_start)
    else $error("stall start without a fresh start");

  property p_st_release;
    @(posedge ref_clk) disable iff (!nrst)
    st_ff.st_active && meas.iph < CUR_RELEASE |=> !st_ff.st_active ##1
      !st_ff.out.st_start || st_ff.force_on;
  endproperty
  a_st_release: assert property (p_st_release)
    else $error("stall stage did not release");

  property p_st_inactive;
    @(posedge ref_clk) disable iff (!nrst)
    st_ff.st_trip |-> st_ff.st_active;
  endproperty
  a_st_inactive: assert property (p_st_inactive)
    else $error("stall trip outside a start");

  property p_st_trip_time;
    @(posedge ref_clk) disable iff (!nrst)
    $rose(st_ff.st_trip) |-> ({8'h00, $past(st_ff.st_ms)} >= $past(op_ms)) &&
      st_ff.st_pend ##1 log_cnt != $past(log_cnt) || log_cnt[3];
  endproperty
  a_st_trip_time: assert property (p_st_trip_time)
    else $error("stall trip before operate time or not logged");

  property p_force_timeout;
    @(posedge ref_clk) disable iff (!nrst)
    st_ff.force_ms == 20'(FORCE_MS_P) && !ctrl_wr |=> !st_ff.force_on;
  endproperty
  a_force_timeout: assert property (p_force_timeout)
    else $error("force flag outlived its timeout");

  property p_po_count;
    @(posedge ref_clk) disable iff (!nrst)
    $rose(st_ff.po_start) && !$past(wr_go) |->
      st_ff.po_scnt == $past(st_ff.po_scnt) + 16'h0001;
  endproperty
  a_po_count: assert property (p_po_count)
    else $error("phase order start not counted");

  property p_stopped;
    @(posedge ref_clk) disable iff (!nrst)
    motor_stopped |-> $past(meas.avg) < CUR_STOP;
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("stopped flag without low current");
endmodule

// file: prot_pkg.sv
// Shared constants and carriers for the motor stall and phase order block.
// Assumes currents in hundredths of motor nominal current (100 = 1.00 x).
package prot_pkg;

  // Time base
  localparam int CLK_HZ = 40_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int TENTH_MS = 100;
  localparam int PO_TRIP_MS = 100;
  localparam int START_WIN_MS = 200;
  localparam int FORCE_TIMEOUT_MIN = 5;
  localparam int FORCE_TIMEOUT_MS = FORCE_TIMEOUT_MIN * 60 * MS_PER_S;
  localparam logic [26:0] MS_PER_DAY = 27'h5265c00;

  // Current thresholds, hundredths of nominal
  localparam logic [15:0] CUR_STOP = 16'h000a;
  localparam logic [15:0] PO_AVG_MIN = 16'h0014;
  localparam logic [31:0] PO_RATIO_PCT = 32'h0000_0050;
  localparam logic [15:0] CUR_RELEASE = 16'h0078;
  localparam logic [31:0] PCT_FULL = 32'h0000_0064;

  // Reset values
  localparam logic [15:0] START_LVL_RST = 16'h012c;
  localparam logic [15:0] NOM_START_RST = 16'h0258;
  localparam logic [15:0] DT_TIME_RST = 16'h0064;
  localparam logic [15:0] INV_MULT_RST = 16'h0064;
  localparam logic [15:0] IMOT_AMPS_RST = 16'h0064;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] START_LVL_OFS = 8'h04;
  localparam logic [7:0] NOM_START_OFS = 8'h08;
  localparam logic [7:0] DT_TIME_OFS = 8'h0c;
  localparam logic [7:0] INV_MULT_OFS = 8'h10;
  localparam logic [7:0] IMOT_AMPS_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam logic [7:0] RATIO_OFS = 8'h1c;
  localparam logic [7:0] PHASE_CUR_OFS = 8'h20;
  localparam logic [7:0] LVL_AMPS_OFS = 8'h24;
  localparam logic [7:0] NOMST_AMPS_OFS = 8'h28;
  localparam logic [7:0] PO_CNT_OFS = 8'h2c;
  localparam logic [7:0] ST_CNT_OFS = 8'h30;
  localparam logic [7:0] PO_REC_OFS = 8'h34;
  localparam logic [7:0] ST_REC_OFS = 8'h38;
  localparam logic [7:0] DATE_OFS = 8'h3c;
  localparam logic [7:0] TOD_OFS = 8'h40;
  localparam logic [7:0] LOG_SEL_OFS = 8'h44;
  localparam logic [7:0] LOG_DATE_OFS = 8'h48;
  localparam logic [7:0] LOG_TOD_OFS = 8'h4c;
  localparam logic [7:0] LOG_INFO_OFS = 8'h50;

  // CTRL field positions
  localparam int CTRL_FORCE_BIT = 0;
  localparam int CTRL_INV_BIT = 1;
  localparam int CTRL_GRP_LSB = 2;
  localparam int CTRL_FST_LSB = 4;

  localparam int LOG_DEPTH = 8;

  typedef struct packed {
    logic [15:0] avg;
    logic [15:0] iph;
    logic [15:0] neg;
    logic [15:0] pos;
  } meas_t;

  typedef struct packed {
    logic po_start;
    logic po_trip;
    logic st_start;
    logic st_trip;
  } stage_out_t;

  typedef struct packed {
    logic [31:0] date;
    logic [26:0] tod;
    logic stage;
    logic [1:0] grp;
    logic [7:0] elapsed_delay_pct;
    logic [15:0] flt;
  } log_entry_t;

endpackage

// file: fault_log_mem.sv
// Ring store of the most recent fault records, newest at read index 0.
// Assumes DEPTH is a power of two and one write per cycle at most.
`timescale 1ns/10ps
module fault_log_mem import prot_pkg::*; #(
  parameter int DEPTH = LOG_DEPTH,
  parameter int WIDTH = $bits(log_entry_t)
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic we,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] rsel,
  output logic [WIDTH-1:0] rdata,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW:0] cnt;
    logic [WIDTH-1:0] rd;
  } mstate_t;

  mstate_t st_ff;
  mstate_t nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] ridx;

  assign ridx = st_ff.wptr - AW'(1) - rsel;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rd = mem[ridx];
    if (we) begin
      nxt_st.wptr = st_ff.wptr + AW'(1);
      if (st_ff.cnt != (AW+1)'(DEPTH)) begin
        nxt_st.cnt = st_ff.cnt + (AW+1)'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[st_ff.wptr] <= wdata;
    end
  end

  assign rdata = st_ff.rd;
  assign count = st_ff.cnt;
endmodule

// file: meas_front_end.sv
// Model of the current measurement front end feeding the protection block.
// Assumes the bench sets target magnitudes on ref_clk; one cycle of latency.
`timescale 1ns/10ps
module meas_front_end import prot_pkg::*; (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire meas_t target,
  output meas_t meas
);
  // Fundamental magnitudes only, registered like a real filter output
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meas <= '0;
    end else begin
      meas <= target;
    end
  end
endmodule

// file: tb_top.sv
// Self-checking bench for the stall and phase order protection block.
// Assumes a 10-cycle ms tick and a 20 ms force timeout in simulation.
`timescale 1ns/10ps
`define CHK(nm, e, a) \
  begin \
    checked++; \
    if ((a) !== (e)) begin \
      failures++; \
      $display("Error %s expected %0h seen %0h", nm, e, a); \
    end \
  end
module tb_top import prot_pkg::*;;
  localparam int MS_SIM = 10;
  logic ref_clk;
  logic nrst;
  logic [7:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  meas_t target;
  meas_t meas;
  logic panel_button;
  stage_out_t stage_out;
  logic force_active;
  logic motor_stopped;
  int failures;
  int checked;
  int cycles;
  logic [31:0] rd;

  meas_front_end u_fe (.ref_clk(ref_clk), .nrst(nrst), .target(target),
    .meas(meas));
  motor_stall_phase_order_protect #(.MS_CYCLES_P(MS_SIM), .FORCE_MS_P(20))
    u_dut (.ref_clk(ref_clk), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .meas(meas), .panel_button(panel_button),
    .stage_out(stage_out), .force_active(force_active),
    .motor_stopped(motor_stopped));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      print_verdict();
    end
  end

  task bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0) @(posedge ref_clk);
    write <= 1'b0;
  endtask

  task chk_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge ref_clk);
    address <= a;
    read <= 1'b1;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0) @(posedge ref_clk);
    rd = readdata;
    read <= 1'b0;
    `CHK(nm, e, rd)
  endtask

  task set_meas(input logic [15:0] a, i, n, p);
    @(posedge ref_clk);
    target <= '{avg: a, iph: i, neg: n, pos: p};
  endtask

  task wait_ms(input int n);
    repeat (n * MS_SIM) @(posedge ref_clk);
  endtask

  task t_reset;
    chk_rd(NOM_START_OFS, 32'h0000_0258, "nom_start");
    chk_rd(NOMST_AMPS_OFS, 32'h0000_0258, "nom_amps");
    bus_wr(IMOT_AMPS_OFS, 32'h0000_00c8);
    chk_rd(LVL_AMPS_OFS, 32'h0000_0258, "lvl_amps");
    chk_rd(NOMST_AMPS_OFS, 32'h0000_04b0, "nom_amps2");
    bus_wr(LVL_AMPS_OFS, 32'h0000_ffff);
    chk_rd(LVL_AMPS_OFS, 32'h0000_0258, "lvl_ro");
    chk_rd(8'hfc, 32'h0000_0000, "unmapped");
    `CHK("stopped", 1'b1, motor_stopped)
    $display("test reset_values done");
  endtask

  task t_phase_order;
    set_meas(16'h0032, 16'h00c8, 16'h005a, 16'h0064);
    wait_ms(50);
    `CHK("po_start", 1'b1, stage_out.po_start)
    `CHK("stopped", 1'b0, motor_stopped)
    chk_rd(RATIO_OFS, 32'h0000_005a, "ratio");
    bus_wr(PHASE_CUR_OFS, 32'h0000_ffff);
    chk_rd(PHASE_CUR_OFS, 32'h0000_00c8, "phase_cur");
    wait_ms(45);
    `CHK("po_trip", 1'b0, stage_out.po_trip)
    wait_ms(10);
    `CHK("po_trip", 1'b1, stage_out.po_trip)
    chk_rd(PO_CNT_OFS, 32'h0001_0001, "po_cnt");
    chk_rd(PO_REC_OFS, 32'h005a_0064, "po_rec");
    bus_wr(LOG_SEL_OFS, 32'h0000_0000);
    chk_rd(LOG_INFO_OFS, 32'h0864_005a, "po_log");
    set_meas(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    wait_ms(20);
    `CHK("po_start", 1'b0, stage_out.po_start)
    $display("test phase_order done");
  endtask

  task t_stall_fixed;
    bus_wr(DATE_OFS, 32'h0001_0203);
    bus_wr(DT_TIME_OFS, 32'h0000_0005);
    set_meas(16'h0190, 16'h0190, 16'h0000, 16'h0190);
    wait_ms(450);
    `CHK("st_start", 1'b1, stage_out.st_start)
    `CHK("st_trip", 1'b0, stage_out.st_trip)
    wait_ms(70);
    `CHK("st_trip", 1'b1, stage_out.st_trip)
    set_meas(16'h007d, 16'h007d, 16'h0000, 16'h007d);
    wait_ms(5);
    `CHK("st_hold", 1'b1, stage_out.st_start)
    set_meas(16'h0064, 16'h0064, 16'h0000, 16'h0064);
    wait_ms(5);
    `CHK("st_rel", 1'b0, stage_out.st_start)
    chk_rd(ST_CNT_OFS, 32'h0001_0001, "st_cnt");
    chk_rd(ST_REC_OFS, 32'h0190_0064, "st_rec");
    bus_wr(LOG_SEL_OFS, 32'h0000_0000);
    chk_rd(LOG_INFO_OFS, 32'h0c64_0190, "st_log");
    chk_rd(LOG_DATE_OFS, 32'h0001_0203, "log_date");
    bus_wr(ST_CNT_OFS, 32'h0000_0000);
    chk_rd(ST_CNT_OFS, 32'h0000_0000, "st_clr");
    $display("test stall_fixed done");
  endtask

  task t_stall_slow;
    set_meas(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    wait_ms(20);
    set_meas(16'h00c8, 16'h00c8, 16'h0000, 16'h00c8);
    wait_ms(250);
    `CHK("st_run", 1'b0, stage_out.st_start)
    set_meas(16'h0190, 16'h0190, 16'h0000, 16'h0190);
    wait_ms(50);
    `CHK("st_slow", 1'b0, stage_out.st_start)
    set_meas(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    wait_ms(20);
    $display("test stall_slow done");
  endtask

  task t_inverse;
    bus_wr(INV_MULT_OFS, 32'h0000_000a);
    bus_wr(CTRL_OFS, 32'h0000_000e);
    set_meas(16'h04b0, 16'h04b0, 16'h0000, 16'h04b0);
    wait_ms(200);
    `CHK("inv_start", 1'b1, stage_out.st_start)
    `CHK("inv_trip", 1'b0, stage_out.st_trip)
    wait_ms(70);
    `CHK("inv_trip", 1'b1, stage_out.st_trip)
    set_meas(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    wait_ms(5);
    bus_wr(LOG_SEL_OFS, 32'h0000_0000);
    chk_rd(LOG_INFO_OFS, 32'h0f64_04b0, "inv_log");
    bus_wr(CTRL_OFS, 32'h0000_0000);
    $display("test inverse done");
  endtask

  task t_force;
    bus_wr(CTRL_OFS, 32'h0000_00a1);
    repeat (5) @(posedge ref_clk);
    `CHK("force", 1'b1, force_active)
    `CHK("forced", 4'b1010, stage_out)
    chk_rd(STATUS_OFS, 32'h0000_003a, "status");
    chk_rd(CTRL_OFS, 32'h0000_00a1, "ctrl");
    repeat (100) @(posedge ref_clk);
    panel_button <= 1'b1;
    repeat (5) @(posedge ref_clk);
    panel_button <= 1'b0;
    repeat (150) @(posedge ref_clk);
    `CHK("force_kept", 1'b1, force_active)
    repeat (100) @(posedge ref_clk);
    `CHK("force_off", 1'b0, force_active)
    `CHK("unforced", 4'b0000, stage_out)
    $display("test force done");
  endtask

  initial begin
    nrst = 1'b0;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    target = '0;
    panel_button = 1'b0;
    failures = 0;
    checked = 0;
    cycles = 0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_phase_order();
    t_stall_fixed();
    t_stall_slow();
    t_inverse();
    t_force();
    print_verdict();
  end
endmodule
